// file: src/iqe_params.svh
`ifndef IQE_PARAMS_SVH
`define IQE_PARAMS_SVH

// Clock rate of the engine and the derived timing counts
`define IQE_CLK_HZ 100000000
`define IQE_REF_OUT_HZ 10000000
`define IQE_REF_HALF_CYC (`IQE_CLK_HZ / (2 * `IQE_REF_OUT_HZ))
`define IQE_LOWBAND_HZ 2000000
`define IQE_LOWBAND_CYC (`IQE_CLK_HZ / `IQE_LOWBAND_HZ)

// Shortest sample hold in clock cycles
`define IQE_STEP_MIN 16'h001e

// Input bit buffer capacity in bits
`define IQE_BUF_BITS 102400

// DAC code window and zero reference
`define IQE_CODE_MIN 12'h07d
`define IQE_CODE_MAX 12'h465
`define IQE_CODE_ZERO 12'h271

// Serial-to-parallel selector codes
`define IQE_SP_BYPASS 3'h1
`define IQE_SP_GROUP 3'h2
`define IQE_SP_INTERLEAVE 3'h3
`define IQE_SP_MSK 3'h4

// Code converter selector codes
`define IQE_CONV_BYPASS 2'h1
`define IQE_CONV_GRAY 2'h2
`define IQE_CONV_GMSK 2'h3

// I/Q source selection codes
`define IQE_IQ_NONE 2'h0
`define IQE_IQ_INTERNAL 2'h1
`define IQE_IQ_EXTERNAL 2'h2

// Reference clock selection codes
`define IQE_CLK_INT 2'h0
`define IQE_CLK_INT_OUT 2'h1
`define IQE_CLK_EXT 2'h2

// Raw sample pair layout: first value (Q) high, second value (I) low
`define IQE_RAW_Q_MSB 23
`define IQE_RAW_Q_LSB 12
`define IQE_RAW_I_MSB 11
`define IQE_RAW_I_LSB 0

`endif

// file: src/iqe_pkg.sv
package iqe_pkg;

  // One DAC code
  typedef logic [11:0] iqe_code_t;

  // Symbol gathering sequence
  typedef enum logic [2:0] {
    GS_IDLE,
    GS_ADDR,
    GS_TAKE,
    GS_CONV,
    GS_HOLD
  } iqe_gather_e;

endpackage : iqe_pkg

// file: src/iqe_tick_if.sv
`timescale 1ns/1ps
// Period and restart toward a tick divider, tick back
interface iqe_tick_if #(parameter int W = 16) ();
  logic [W-1:0] period;
  logic restart;
  logic tick;
  modport div(input period, input restart, output tick);
  modport user(output period, output restart, input tick);
endinterface : iqe_tick_if

// file: src/iqe_tick_div.sv
`timescale 1ns/1ps
module iqe_tick_div #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic rst,
  iqe_tick_if.div tk
);

  logic [W-1:0] cnt_q; // Cycles since last tick
  logic tick_q; // One-cycle tick

  assign tk.tick = tick_q;

  // Count to period, pulse, restart
  always_ff @(posedge clock) begin
    if (rst || tk.restart) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= tk.period - W'(1)) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick_q <= 1'b0;
    end
  end

endmodule : iqe_tick_div

// file: src/iqe_engine.sv
// How it works
// - Selector 1: each bit is one symbol
// - Selector 2: consecutive Y-bit groups form symbols
// - Selector 3: bits interleaved across Y symbols
// - Selector 4: dedicated MSK-style phase mapping
// - Y-bit index selects one of 2^Y patterns
// - Converter 1 passes symbols unchanged
// - Converter 2 outputs Gray code of symbol
// - Converter 3 applies Gaussian-style transition shaping
// - Symbol indexes I/Q patterns, samples emitted in order
// - Samples are 12-bit codes within 125..1125
// - Raw pair: first value Q, second I
// - Each sample held for step count cycles
// - Step count never shorter than 30
// - Bit buffer holds 100 kbit, longer refused
// - Phase advance per bit is 90 deg times M
// - Default reference selection leaves clock port undriven
// - Internal output selection drives 10 MHz reference
// - Source None: carrier only, no modulation
// - Source Internal: engine waveform to modulator
// - Low band: DAC path, samples at 2 MHz
`timescale 1ns/1ps
`include "iqe_params.svh"
module iqe_engine #(
  parameter int BUF_BITS = `IQE_BUF_BITS,
  parameter int Y_MAX = 4,
  parameter int SAMP_MAX = 64,
  parameter int RAW_DEPTH = 4096
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] sp_mode,
  input wire logic [2:0] sym_width,
  input wire logic [1:0] conv_mode,
  input wire logic [1:0] phase_mult,
  input wire logic [$clog2(SAMP_MAX):0] pat_len,
  input wire logic [15:0] step_count,
  input wire logic [$clog2(BUF_BITS):0] bit_len,
  input wire logic raw_mode,
  input wire logic [$clog2(RAW_DEPTH):0] raw_len,
  input wire logic [1:0] iq_sel,
  input wire logic [1:0] clk_sel,
  input wire logic low_band,
  input wire logic flag_clr,
  input wire logic bit_wr_en,
  input wire logic [$clog2(BUF_BITS):0] bit_wr_addr,
  input wire logic bit_wr_data,
  input wire logic pat_wr_en,
  input wire logic pat_wr_quad,
  input wire logic [Y_MAX-1:0] pat_wr_index,
  input wire logic [$clog2(SAMP_MAX)-1:0] pat_wr_sample,
  input wire logic [11:0] pat_wr_code,
  input wire logic raw_wr_en,
  input wire logic [$clog2(RAW_DEPTH)-1:0] raw_wr_addr,
  input wire logic [23:0] raw_wr_data,
  input wire logic ref_clk_in,
  output logic [11:0] dac_i_q,
  output logic [11:0] dac_q_q,
  output logic dac_update_q,
  output logic [Y_MAX-1:0] sym_out_q,
  output logic iq_internal_q,
  output logic iq_external_q,
  output logic carrier_only_q,
  output logic low_band_path_q,
  output logic ref_clk_out_q,
  output logic ref_clk_oe_q,
  output logic ext_ref_level_q,
  output logic load_refused_q,
  output logic underrun_q
);

  localparam int BAW = $clog2(BUF_BITS); // Bit buffer address width
  localparam int SAW = $clog2(SAMP_MAX); // Sample index width
  localparam int RAW = $clog2(RAW_DEPTH); // Raw address width
  localparam int PAW = Y_MAX + SAW; // Pattern memory address width

  // Clamp a code into the DAC window
  function automatic iqe_pkg::iqe_code_t clamp_code(input iqe_pkg::iqe_code_t c);
    iqe_pkg::iqe_code_t r;
    r = c;
    if (c < `IQE_CODE_MIN) begin
      r = `IQE_CODE_MIN;
    end else if (c > `IQE_CODE_MAX) begin
      r = `IQE_CODE_MAX;
    end
    return r;
  endfunction : clamp_code

  // Storage
  logic bit_mem [BUF_BITS]; // Input bit buffer
  iqe_pkg::iqe_code_t pat_i_mem [2**PAW]; // In-phase pattern samples
  iqe_pkg::iqe_code_t pat_q_mem [2**PAW]; // Quadrature pattern samples
  logic [23:0] raw_mem [RAW_DEPTH]; // Raw Q,I pairs

  // Gathering state
  iqe_pkg::iqe_gather_e gs_q; // Gather sequence state
  logic [BAW:0] base_q; // Group, block or bit start
  logic [2:0] lane_q; // Symbol within an interleave block
  logic [2:0] pos_q; // Bit within current symbol
  logic [Y_MAX-1:0] acc_q; // Bits collected so far
  logic bit_rd_q; // Bit read from buffer
  logic in_range_q; // Read address was inside stream
  logic [1:0] phase_q; // Quadrant phase for MSK mapping
  logic prev_lsb_q; // Previous symbol bit for shaping
  logic [Y_MAX-1:0] next_sym_q; // Converted symbol waiting
  logic next_vld_q; // Waiting symbol present

  // Playback state
  logic [Y_MAX-1:0] cur_sym_q; // Symbol now playing
  logic [SAW-1:0] samp_q; // Sample within pattern
  logic playing_q; // A symbol has been loaded
  logic [RAW-1:0] raw_idx_q; // Raw playback index
  iqe_pkg::iqe_code_t pat_i_rd_q; // Pattern read, in-phase
  iqe_pkg::iqe_code_t pat_q_rd_q; // Pattern read, quadrature
  logic [23:0] raw_rd_q; // Raw pair read
  logic ref_s1_q; // Reference pin first sync stage
  logic ref_s2_q; // Reference pin second sync stage

  // Combinational helpers
  logic [2:0] ywid; // Legal symbol width
  logic [2:0] nbits; // Bits gathered per symbol
  logic [BAW:0] rd_addr; // Buffer address to read
  logic [BAW:0] next_base; // Start after this symbol
  logic [2:0] next_lane; // Lane after this symbol
  logic [Y_MAX-1:0] ymask; // Mask of Y low bits
  logic [Y_MAX-1:0] conv_sym; // Converter output
  logic [1:0] msk_phase; // Phase after this bit
  logic sym_take; // Playback takes waiting symbol
  logic [15:0] step_eff; // Hold count after limiting

  iqe_tick_if #(.W(16)) play_tk ();
  iqe_tick_if #(.W(16)) ref_tk ();

  // Sample pacing divider
  iqe_tick_div #(.W(16)) u_play_div (
    .clock(clock),
    .rst(rst),
    .tk(play_tk)
  );

  // Reference output half-period divider
  iqe_tick_div #(.W(16)) u_ref_div (
    .clock(clock),
    .rst(rst),
    .tk(ref_tk)
  );

  // Hold count: step count, floored, or fixed low-band rate
  always_comb begin
    step_eff = (step_count < `IQE_STEP_MIN) ? `IQE_STEP_MIN : step_count;
    if (low_band) begin
      step_eff = 16'(`IQE_LOWBAND_CYC);
    end
  end
  assign play_tk.period = step_eff;
  assign play_tk.restart = ~run;
  assign ref_tk.period = 16'(`IQE_REF_HALF_CYC);
  assign ref_tk.restart = (clk_sel != `IQE_CLK_INT_OUT);

  // Symbol width and bits per symbol by mode
  always_comb begin
    ywid = sym_width;
    if (sym_width == 3'h0) begin
      ywid = 3'h1;
    end else if (sym_width > 3'(Y_MAX)) begin
      ywid = 3'(Y_MAX);
    end
    ymask = Y_MAX'((1 << ywid) - 1);
    if (sp_mode == `IQE_SP_GROUP || sp_mode == `IQE_SP_INTERLEAVE) begin
      nbits = ywid;
    end else begin
      nbits = 3'h1;
    end
  end

  // Buffer address and next pointers
  always_comb begin
    rd_addr = base_q + (BAW+1)'(pos_q);
    next_base = base_q + (BAW+1)'(1);
    next_lane = 3'h0;
    unique case (sp_mode)
      `IQE_SP_GROUP: begin
        next_base = base_q + (BAW+1)'(ywid);
      end
      `IQE_SP_INTERLEAVE: begin
        rd_addr = base_q + (BAW+1)'(pos_q) * (BAW+1)'(ywid) + (BAW+1)'(lane_q);
        if (lane_q == ywid - 3'h1) begin
          next_base = base_q + (BAW+1)'(ywid) * (BAW+1)'(ywid);
        end else begin
          next_base = base_q;
          next_lane = lane_q + 3'h1;
        end
      end
      default: begin
        next_base = base_q + (BAW+1)'(1);
      end
    endcase
    if (next_base >= (BAW+1)'(bit_len)) begin
      next_base = '0;
      next_lane = 3'h0;
    end
  end

  // Phase step and code conversion
  always_comb begin
    msk_phase = acc_q[0] ? phase_q + phase_mult : phase_q - phase_mult;
    conv_sym = acc_q & ymask;
    if (sp_mode == `IQE_SP_MSK) begin
      conv_sym = Y_MAX'({acc_q[0], msk_phase});
    end else begin
      unique case (conv_mode)
        `IQE_CONV_GRAY: conv_sym = ((acc_q >> 1) ^ acc_q) & ymask;
        `IQE_CONV_GMSK: conv_sym = ((acc_q << 1) | Y_MAX'(prev_lsb_q)) & ymask;
        default: conv_sym = acc_q & ymask;
      endcase
    end
  end

  // Buffer write, refused beyond capacity
  always_ff @(posedge clock) begin
    if (bit_wr_en && bit_wr_addr < (BAW+1)'(BUF_BITS)) begin
      bit_mem[bit_wr_addr[BAW-1:0]] <= bit_wr_data;
    end
  end

  // Refused load flag, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      load_refused_q <= 1'b0;
    end else if ((bit_wr_en && bit_wr_addr >= (BAW+1)'(BUF_BITS))
                 || bit_len > (BAW+1)'(BUF_BITS)) begin
      load_refused_q <= 1'b1;
    end else if (flag_clr) begin
      load_refused_q <= 1'b0;
    end
  end

  // Pattern write, codes clamped
  always_ff @(posedge clock) begin
    if (pat_wr_en && pat_wr_quad) begin
      pat_q_mem[{pat_wr_index, pat_wr_sample}] <= clamp_code(pat_wr_code);
    end
    if (pat_wr_en && !pat_wr_quad) begin
      pat_i_mem[{pat_wr_index, pat_wr_sample}] <= clamp_code(pat_wr_code);
    end
  end

  // Raw pair write
  always_ff @(posedge clock) begin
    if (raw_wr_en) begin
      raw_mem[raw_wr_addr] <= raw_wr_data;
    end
  end

  // Buffer read, bits past the stream end read as zero
  always_ff @(posedge clock) begin
    bit_rd_q <= bit_mem[rd_addr[BAW-1:0]];
    in_range_q <= rd_addr < (BAW+1)'(bit_len);
  end

  // Gather sequence: read bits, convert, offer symbol
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      gs_q <= iqe_pkg::GS_IDLE;
      base_q <= '0;
      lane_q <= 3'h0;
      pos_q <= 3'h0;
      acc_q <= '0;
      phase_q <= 2'h0;
      prev_lsb_q <= 1'b0;
    end else begin
      unique case (gs_q)
        iqe_pkg::GS_IDLE: begin
          pos_q <= 3'h0;
          acc_q <= '0;
          gs_q <= iqe_pkg::GS_ADDR;
        end
        iqe_pkg::GS_ADDR: begin
          gs_q <= iqe_pkg::GS_TAKE;
        end
        iqe_pkg::GS_TAKE: begin
          acc_q <= {acc_q[Y_MAX-2:0], bit_rd_q & in_range_q};
          if (pos_q == nbits - 3'h1) begin
            gs_q <= iqe_pkg::GS_HOLD;
          end else begin
            pos_q <= pos_q + 3'h1;
            gs_q <= iqe_pkg::GS_ADDR;
          end
        end
        iqe_pkg::GS_HOLD: begin
          if (!next_vld_q) begin
            gs_q <= iqe_pkg::GS_CONV;
          end
        end
        iqe_pkg::GS_CONV: begin
          if (sp_mode == `IQE_SP_MSK) begin
            phase_q <= msk_phase;
          end
          prev_lsb_q <= acc_q[0];
          base_q <= next_base;
          lane_q <= next_lane;
          pos_q <= 3'h0;
          acc_q <= '0;
          gs_q <= iqe_pkg::GS_ADDR;
        end
      endcase
    end
  end

  // Playback takes the waiting symbol at pattern end
  assign sym_take = play_tk.tick && next_vld_q && !raw_mode
                    && (!playing_q || 7'(samp_q) == pat_len - 7'h1);

  // Waiting symbol slot
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      next_vld_q <= 1'b0;
      next_sym_q <= '0;
    end else if (gs_q == iqe_pkg::GS_CONV) begin
      next_vld_q <= 1'b1;
      next_sym_q <= conv_sym;
    end else if (sym_take) begin
      next_vld_q <= 1'b0;
    end
  end

  // Pattern and raw sample stepping
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      cur_sym_q <= '0;
      samp_q <= '0;
      playing_q <= 1'b0;
      raw_idx_q <= '0;
    end else if (play_tk.tick) begin
      if (raw_mode) begin
        if ((RAW+1)'(raw_idx_q) >= raw_len - (RAW+1)'(1)) begin
          raw_idx_q <= '0;
        end else begin
          raw_idx_q <= raw_idx_q + RAW'(1);
        end
      end else if (sym_take) begin
        cur_sym_q <= next_sym_q;
        samp_q <= '0;
        playing_q <= 1'b1;
      end else if (playing_q) begin
        if (7'(samp_q) >= pat_len - 7'h1) begin
          samp_q <= '0;
        end else begin
          samp_q <= samp_q + SAW'(1);
        end
      end
    end
  end

  // Starved flag, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      underrun_q <= 1'b0;
    end else if (play_tk.tick && playing_q && !next_vld_q && !raw_mode
                 && 7'(samp_q) == pat_len - 7'h1) begin
      underrun_q <= 1'b1;
    end else if (flag_clr) begin
      underrun_q <= 1'b0;
    end
  end

  // Sample memory reads for the current position
  always_ff @(posedge clock) begin
    pat_i_rd_q <= pat_i_mem[{cur_sym_q, samp_q}];
    pat_q_rd_q <= pat_q_mem[{cur_sym_q, samp_q}];
    raw_rd_q <= raw_mem[raw_idx_q];
  end

  // DAC codes, zero reference unless internal source plays
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_i_q <= `IQE_CODE_ZERO;
      dac_q_q <= `IQE_CODE_ZERO;
      dac_update_q <= 1'b0;
      sym_out_q <= '0;
    end else begin
      dac_update_q <= play_tk.tick && run;
      if (iq_sel != `IQE_IQ_INTERNAL || !run) begin
        dac_i_q <= `IQE_CODE_ZERO;
        dac_q_q <= `IQE_CODE_ZERO;
      end else if (play_tk.tick && raw_mode) begin
        dac_q_q <= clamp_code(raw_rd_q[`IQE_RAW_Q_MSB:`IQE_RAW_Q_LSB]);
        dac_i_q <= clamp_code(raw_rd_q[`IQE_RAW_I_MSB:`IQE_RAW_I_LSB]);
      end else if (play_tk.tick && playing_q) begin
        dac_i_q <= pat_i_rd_q;
        dac_q_q <= pat_q_rd_q;
        sym_out_q <= cur_sym_q;
      end
    end
  end

  // Source routing and output path selection
  always_ff @(posedge clock) begin
    if (rst) begin
      iq_internal_q <= 1'b0;
      iq_external_q <= 1'b0;
      carrier_only_q <= 1'b1;
      low_band_path_q <= 1'b0;
    end else begin
      carrier_only_q <= (iq_sel != `IQE_IQ_INTERNAL) && (iq_sel != `IQE_IQ_EXTERNAL);
      iq_internal_q <= (iq_sel == `IQE_IQ_INTERNAL);
      iq_external_q <= (iq_sel == `IQE_IQ_EXTERNAL);
      low_band_path_q <= low_band;
    end
  end

  // Reference clock port drive
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_clk_out_q <= 1'b0;
      ref_clk_oe_q <= 1'b0;
    end else begin
      ref_clk_oe_q <= (clk_sel == `IQE_CLK_INT_OUT);
      if (clk_sel != `IQE_CLK_INT_OUT) begin
        ref_clk_out_q <= 1'b0;
      end else if (ref_tk.tick) begin
        ref_clk_out_q <= ~ref_clk_out_q;
      end
    end
  end

  // External reference pin synchronised before use
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ext_ref_level_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_clk_in;
      ref_s2_q <= ref_s1_q;
      ext_ref_level_q <= (clk_sel == `IQE_CLK_EXT) && ref_s2_q;
    end
  end

endmodule : iqe_engine

// file: test/iqe_engine_chk.sv
`timescale 1ns/1ps
// Port-level checker for the I/Q engine
module iqe_engine_chk #(
  parameter int BUF_BITS = 102400
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [15:0] step_count,
  input wire logic low_band,
  input wire logic [1:0] iq_sel,
  input wire logic [1:0] clk_sel,
  input wire logic bit_wr_en,
  input wire logic [$clog2(BUF_BITS):0] bit_wr_addr,
  input wire logic [11:0] dac_i_q,
  input wire logic [11:0] dac_q_q,
  input wire logic dac_update_q,
  input wire logic iq_internal_q,
  input wire logic carrier_only_q,
  input wire logic low_band_path_q,
  input wire logic ref_clk_out_q,
  input wire logic ref_clk_oe_q,
  input wire logic load_refused_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] gap_q; // Cycles since the last DAC update
  logic seen_q; // An update has been seen in this run
  logic [15:0] step_eff; // Hold count after the floor
  assign step_eff = (step_count < 16'h001e) ? 16'h001e : step_count;
  // Gap counter, restarted by every update and cleared outside a run
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      gap_q <= 16'h0001;
      seen_q <= 1'b0;
    end else if (dac_update_q) begin
      gap_q <= 16'h0001;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  a_code_range: assert property (dac_i_q >= 12'h07d && dac_i_q <= 12'h465 &&
    dac_q_q >= 12'h07d && dac_q_q <= 12'h465) else $error("DAC code out of window");
  a_step_hold: assert property ((dac_update_q && seen_q && !low_band) |->
    gap_q == step_eff) else $error("hold not step count");
  a_lowband_rate: assert property ((dac_update_q && seen_q && low_band) |->
    gap_q == 16'h0032) else $error("low band spacing wrong");
  a_update_gap: assert property (dac_update_q |=> !dac_update_q [*8])
    else $error("updates too close");
  a_idle_zero: assert property ((!$past(rst) && $past(iq_sel) != 2'h1 &&
    $past(iq_sel, 2) != 2'h1) |-> (dac_i_q == 12'h271 && dac_q_q == 12'h271))
    else $error("DAC not at zero");
  a_carrier_only: assert property (!$past(rst) |->
    carrier_only_q == ($past(iq_sel) == 2'h0)) else $error("carrier flag wrong");
  a_internal_route: assert property (!$past(rst) |->
    iq_internal_q == ($past(iq_sel) == 2'h1)) else $error("internal route wrong");
  a_lowband_path: assert property (!$past(rst) |->
    low_band_path_q == $past(low_band)) else $error("low band path wrong");
  a_ref_undriven: assert property (!$past(rst) |->
    ref_clk_oe_q == ($past(clk_sel) == 2'h1)) else $error("clock port enable wrong");
  a_ref_period: assert property (@(posedge clock) disable iff (rst || clk_sel != 2'h1)
    ($changed(ref_clk_out_q) && ref_clk_oe_q) |=>
    $stable(ref_clk_out_q) [*4] ##1 $changed(ref_clk_out_q))
    else $error("reference period wrong");
  a_refuse_flag: assert property ((bit_wr_en && bit_wr_addr >= BUF_BITS) |=>
    load_refused_q) else $error("oversize load not flagged");
  c_low_band: cover property (dac_update_q && seen_q && low_band);
  c_ref_out: cover property (ref_clk_oe_q ##1 $changed(ref_clk_out_q));
  c_refused: cover property ($rose(load_refused_q));
endmodule : iqe_engine_chk

bind iqe_engine iqe_engine_chk #(.BUF_BITS(BUF_BITS)) u_iqe_engine_chk (.clock, .rst, .run,
  .step_count, .low_band, .iq_sel, .clk_sel, .bit_wr_en, .bit_wr_addr, .dac_i_q, .dac_q_q,
  .dac_update_q, .iq_internal_q, .carrier_only_q, .low_band_path_q, .ref_clk_out_q,
  .ref_clk_oe_q, .load_refused_q);

// file: test/iqe_dac_model.sv
`timescale 1ns/1ps
// Dual DAC on the far side, plus the outside reference source
module iqe_dac_model (
  input wire logic clock,
  input wire logic [11:0] dac_i,
  input wire logic [11:0] dac_q,
  input wire logic update,
  input wire logic ext_sel,
  output logic ref_out
);
  logic [23:0] seen[$]; // Captured pairs, Q high and I low
  // Latch a pair on each update; the zero level is idle, not a sample
  always @(posedge clock) begin
    if (update && dac_i !== 12'h271) begin
      seen.push_back({dac_q, dac_i});
    end
  end
  // 20 MHz source only while the block expects it, low otherwise
  // Edges kept off the clock edges so the pin never races the sampler
  initial begin
    ref_out = 1'b0;
    #2;
    forever #25 ref_out = ext_sel ? ~ref_out : 1'b0;
  end
endmodule : iqe_dac_model

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock, rst, run, raw_mode, low_band, flag_clr, bit_wr_en, bit_wr_data;
  logic pat_wr_en, pat_wr_quad, raw_wr_en, ref_clk_in;
  logic [2:0] sp_mode, sym_width;
  logic [1:0] conv_mode, phase_mult, iq_sel, clk_sel;
  logic [6:0] pat_len;
  logic [15:0] step_count;
  logic [10:0] bit_len, bit_wr_addr; // Buffer shrunk to 1024 bits
  logic [12:0] raw_len;
  logic [3:0] pat_wr_index, sym_out_q;
  logic [5:0] pat_wr_sample;
  logic [11:0] pat_wr_code, raw_wr_addr, dac_i_q, dac_q_q;
  logic [23:0] raw_wr_data;
  logic dac_update_q, iq_internal_q, iq_external_q, carrier_only_q, low_band_path_q;
  logic ref_clk_out_q, ref_clk_oe_q, ext_ref_level_q, load_refused_q, underrun_q;
  logic [15:0] bits = 16'hcae8; // Stream 1100 1010 1110 1000
  logic [3:0] e[$]; // Expected symbols
  int n_errors, n_checks;
  logic p_ref; // Previous reference level

  iqe_engine #(.BUF_BITS(1024)) u_iqe_engine (.clock, .rst, .run, .sp_mode, .sym_width,
    .conv_mode, .phase_mult, .pat_len, .step_count, .bit_len, .raw_mode, .raw_len, .iq_sel,
    .clk_sel, .low_band, .flag_clr, .bit_wr_en, .bit_wr_addr, .bit_wr_data, .pat_wr_en,
    .pat_wr_quad, .pat_wr_index, .pat_wr_sample, .pat_wr_code, .raw_wr_en, .raw_wr_addr,
    .raw_wr_data, .ref_clk_in, .dac_i_q, .dac_q_q, .dac_update_q, .sym_out_q, .iq_internal_q,
    .iq_external_q, .carrier_only_q, .low_band_path_q, .ref_clk_out_q, .ref_clk_oe_q,
    .ext_ref_level_q, .load_refused_q, .underrun_q);
  iqe_dac_model u_iqe_dac_model (.clock(clock), .dac_i(dac_i_q), .dac_q(dac_q_q),
    .update(dac_update_q), .ext_sel(clk_sel == 2'h2), .ref_out(ref_clk_in));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    conclude();
  end

  // One comparison
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Symbol that a captured pair encodes
  function automatic logic [3:0] sym_of(logic [23:0] p);
    return 4'((p[11:0] - 12'h0c8) >> 4);
  endfunction : sym_of
  // Modes for the next run
  task automatic setm(logic [2:0] sp, logic [2:0] y, logic [1:0] cv);
    sp_mode = sp;
    sym_width = y;
    conv_mode = cv;
  endtask : setm
  // Run until n samples reach the DAC, bounded
  task automatic play(int n);
    u_iqe_dac_model.seen.delete();
    run = 1'b1;
    for (int t = 0; t < 4000 && u_iqe_dac_model.seen.size() < n; t++) begin
      @(negedge clock);
    end
    run = 1'b0;
    repeat (2) @(negedge clock);
  endtask : play
  // Compare captured pairs against the symbol pattern codes
  task automatic expect_syms();
    foreach (e[k]) begin
      check("sample", u_iqe_dac_model.seen[k],
        {12'h3e8 - 12'h010 * e[k], 12'h0c8 + 12'h010 * e[k]});
    end
  endtask : expect_syms
  // Stream bits and one-sample patterns: I rises, Q falls with the index
  task automatic load();
    for (int k = 0; k < 16; k++) begin
      bit_wr_en = 1'b1;
      bit_wr_addr = 11'(k);
      bit_wr_data = bits[15 - k];
      @(negedge clock);
    end
    bit_wr_en = 1'b0;
    for (int s = 0; s < 32; s++) begin
      pat_wr_en = 1'b1;
      pat_wr_index = 4'(s >> 1);
      pat_wr_quad = s[0];
      pat_wr_code = s[0] ? 12'h3e8 - 12'h010 * pat_wr_index : 12'h0c8 + 12'h010 * pat_wr_index;
      @(negedge clock);
    end
    pat_wr_en = 1'b0;
  endtask : load

  // Levels after reset
  task automatic t_reset();
    check("dac_i", dac_i_q, 12'h271);
    check("carrier", carrier_only_q, 1'b1);
  endtask : t_reset
  // Write past the buffer end, then clear
  task automatic t_refuse();
    bit_wr_en = 1'b1;
    bit_wr_addr = 11'h400;
    @(negedge clock);
    bit_wr_en = 1'b0;
    @(negedge clock);
    check("refused", load_refused_q, 1'b1);
    flag_clr = 1'b1;
    @(negedge clock);
    flag_clr = 1'b0;
    @(negedge clock);
    check("cleared", load_refused_q, 1'b0);
  endtask : t_refuse
  // One bit per symbol, past the wrap
  task automatic t_bypass();
    setm(3'h1, 3'h1, 2'h1);
    play(18);
    e = {};
    for (int k = 0; k < 18; k++) begin
      e.push_back({3'h0, bits[15 - k % 16]});
    end
    expect_syms();
  endtask : t_bypass
  // Group, interleave, Gray with a short step, shaping
  task automatic t_group();
    setm(3'h2, 3'h4, 2'h1);
    play(5);
    e = {4'hc, 4'ha, 4'he, 4'h8, 4'hc};
    expect_syms();
    check("sym_out", sym_out_q, 4'hc);
  endtask : t_group
  task automatic t_inter();
    setm(3'h3, 3'h4, 2'h1);
    play(5);
    e = {4'hf, 4'ha, 4'h6, 4'h0, 4'hf};
    expect_syms();
  endtask : t_inter
  task automatic t_gray();
    step_count = 16'h0005;
    setm(3'h2, 3'h4, 2'h2);
    play(5);
    e = {4'ha, 4'hf, 4'h9, 4'hc, 4'ha};
    expect_syms();
    step_count = 16'h001e;
  endtask : t_gray
  task automatic t_shape();
    setm(3'h2, 3'h4, 2'h3);
    play(5);
    e = {4'h8, 4'h4, 4'hc, 4'h0, 4'h8};
    expect_syms();
  endtask : t_shape
  // Phase mapping: data bit on top, quarter-turn steps below
  task automatic t_msk();
    logic [3:0] s;
    logic [3:0] p;
    setm(3'h4, 3'h3, 2'h1);
    play(17);
    for (int k = 1; k < 17; k++) begin
      s = sym_of(u_iqe_dac_model.seen[k]);
      p = sym_of(u_iqe_dac_model.seen[k - 1]);
      check("msk_bit", s[2], bits[15 - k % 16]);
      check("msk_step", s[0] ^ p[0], 1'b1);
    end
  endtask : t_msk
  // Raw pairs in low band, with wrap
  task automatic t_raw();
    logic [23:0] w[3] = '{24'h3e80c8, 24'h12c1f4, 24'h2583e8};
    foreach (w[k]) begin
      raw_wr_en = 1'b1;
      raw_wr_addr = 12'(k);
      raw_wr_data = w[k];
      @(negedge clock);
    end
    raw_wr_en = 1'b0;
    raw_mode = 1'b1;
    low_band = 1'b1;
    play(4);
    for (int k = 0; k < 4; k++) begin
      check("raw", u_iqe_dac_model.seen[k], w[k % 3]);
    end
    check("underrun", underrun_q, 1'b0);
    raw_mode = 1'b0;
    low_band = 1'b0;
  endtask : t_raw
  // Reference selections and source selections
  task automatic t_sel();
    int n;
    for (int c = 0; c < 3; c++) begin
      clk_sel = 2'(c);
      repeat (10) @(negedge clock);
      n = 0;
      repeat (40) begin
        p_ref = (c == 2) ? ext_ref_level_q : ref_clk_out_q;
        @(negedge clock);
        n += int'(p_ref != ((c == 2) ? ext_ref_level_q : ref_clk_out_q));
      end
      check("ref_oe", ref_clk_oe_q, c == 1);
      check("ref_edges", 24'(n), 24'(8 * c));
    end
    for (int c = 0; c < 3; c++) begin
      iq_sel = 2'(c);
      repeat (3) @(negedge clock);
      check("route", {carrier_only_q, iq_internal_q, iq_external_q}, 3'b100 >> c);
    end
    iq_sel = 2'h1;
    repeat (3) @(negedge clock);
  endtask : t_sel

  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    {run, raw_mode, low_band, flag_clr, bit_wr_en, bit_wr_data} = 6'h00;
    {pat_wr_en, pat_wr_quad, raw_wr_en} = 3'h0;
    {bit_wr_addr, raw_wr_addr, raw_wr_data, pat_wr_index, pat_wr_code} = '0;
    setm(3'h1, 3'h1, 2'h1);
    phase_mult = 2'h1;
    pat_len = 7'h01;
    pat_wr_sample = 6'h00;
    step_count = 16'h001e;
    bit_len = 11'h010;
    raw_len = 13'h0003;
    iq_sel = 2'h1;
    clk_sel = 2'h0;
    rst = 1'b1;
    repeat (8) @(negedge clock);
    t_reset();
    rst = 1'b0;
    @(negedge clock);
    t_refuse();
    load();
    t_bypass();
    t_group();
    t_inter();
    t_gray();
    t_shape();
    t_msk();
    t_raw();
    t_sel();
    conclude();
  end
endmodule : tb_top
